// *** bench/csm_modem_test.sv ***
// Purpose: Self-checking bench for the chirp modem parameter core.
// Assumes: csm_peer plays the radio at the far side; one 40 MHz clock.
// Notes:   Reads and symbols are checked against queued expectations.
`timescale 1ns/1ps
module csm_modem_test;
  import csm_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m; int tol;} csm_exp_t;
  logic        clk, rst_n, cyc, stb, we, ack, tx_valid, tx_ready, h, pv, pa;
  logic        rx_go, rx_valid, rng_go, rng_req, rng_rsp, rng_done;
  logic [7:0]  adr, rng_gap;
  logic [3:0]  sel, sf;
  logic [1:0]  bw;
  logic [2:0]  cr;
  logic [31:0] wdat, rdat;
  logic [11:0] tx_sym, rx_sym, rx_sym_d, s;
  logic [15:0] rx_err, rx_err_d, afc;
  logic [15:0] bwk[4];
  logic [7:0]  bwc[4];
  logic [11:0] tx_q[$];
  logic [11:0] rxs[$];
  csm_exp_t    rd_q[$];
  int          miscompares, n_tests, n_done, gap, n_sym, per, cycles, d, g;

  csm_modem csm_modem_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .TX_SYM_VALID_O(tx_valid), .TX_SYM_O(tx_sym), .TX_SYM_READY_I(tx_ready),
    .RX_SYM_VALID_I(rx_valid), .RX_SYM_I(rx_sym_d), .RX_FREQ_ERR_I(rx_err_d),
    .RNG_REQ_I(rng_req), .RNG_RSP_I(rng_rsp), .AFC_TRIM_O(afc), .RNG_DONE_O(rng_done));

  csm_peer csm_peer_inst (.clk_i(clk), .rst_n_i(rst_n), .tx_ready_o(tx_ready), .rx_go_i(rx_go),
    .rx_sym_i(rx_sym), .rx_err_i(rx_err), .rx_valid_o(rx_valid), .rx_sym_o(rx_sym_d),
    .rx_err_o(rx_err_d), .rng_go_i(rng_go), .rng_gap_i(rng_gap), .rng_req_o(rng_req),
    .rng_rsp_o(rng_rsp));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] gv, input logic [31:0] e, input logic [31:0] m,
                     input int tol);
    n_tests++;
    if (^(gv & m) === 1'bx || ((gv & m) !== (e & m) && ((gv > e) ? gv - e : e - gv) > tol))
    begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, gv, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= dv;
    sel  <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input int tol);
    rd_q.push_back('{e, m, tol});
    wb(1'b0, a, 32'h0);
  endtask : rd

  function automatic logic [31:0] modw(input logic hv);
    return {20'h0, hv, cr, 2'b00, bw, sf};
  endfunction : modw

  function automatic logic [31:0] rate();
    return 32'((longint'(sf) * bwk[bw] * 4000) / ((4 + cr) << sf));
  endfunction : rate

  function automatic logic [31:0] drift();
    return 32'((longint'(bwk[bw]) * 1000 * ((sf >= 11) ? 16 : 1)) / (3 << sf));
  endfunction : drift

  // Watches reads, symbol spacing, symbol values, ranging pulses and the run length.
  always @(posedge clk)
  begin
    cycles++;
    gap++;
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
    begin
      chk(rdat, rd_q[0].v, rd_q[0].m, rd_q[0].tol);
      void'(rd_q.pop_front());
    end
    if (tx_valid === 1'b1 && (pv !== 1'b1 || pa === 1'b1))
    begin
      if (n_sym > 0)
        chk({31'h0, gap % per == 0}, 32'h1, 32'h1, 0);
      gap = 0;
      n_sym++;
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_q.size() > 0)
      chk({20'h0, tx_sym}, {20'h0, tx_q.pop_front()}, 32'hfff, 0);
    pv = tx_valid;
    pa = tx_valid & tx_ready;
    if (rng_done === 1'b1)
      n_done++;
    if (cycles == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  initial
  begin
    bwk = '{BW_KHZ0, BW_KHZ1, BW_KHZ2, BW_KHZ3};
    bwc = '{BW_CYC0, BW_CYC1, BW_CYC2, BW_CYC3};
    {rst_n, cyc, stb, we, rx_go, rng_go, adr, sel, wdat, rx_sym, rx_err, rng_gap} = '0;
    void'($urandom(32'hf702));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_MOD, 32'h107, 32'hfff, 0);
    {sf, bw, cr} = {4'd5, 2'd3, 3'd2};
    wb(1'b1, REG_MOD, modw(1'b0));
    rd(REG_STATUS, 32'h2, 32'h6, 0);
    wb(1'b1, REG_STATUS, 32'h2);
    rd(REG_STATUS, 32'h0, 32'h2, 0);
    wb(1'b1, REG_CTRL, 32'h1);
    for (int b = 0; b < 4; b++)
      for (int c = 1; c < 5; c++)
      begin
        sf = (c == 1) ? 4'd5 : (c == 4) ? 4'd12 : 4'(5 + $urandom % 8);
        bw = 2'(b);
        cr = 3'(c);
        h  = 1'($urandom % 2);
        wb(1'b1, REG_MOD, modw(h));
        rd(REG_MOD, modw(h), 32'hfff, 0);
        rd(REG_RATE, rate(), 32'hffffffff, 2);
        rd(REG_DRIFT, drift(), 32'hffffffff, 16);
      end
    wb(1'b1, REG_MOD, (modw(h) & ~32'hf) | 32'hd);
    wb(1'b1, REG_MOD, (modw(h) & ~32'hf) | 32'h4);
    wb(1'b1, REG_MOD, modw(h) & ~32'h700);
    rd(REG_MOD, modw(h), 32'hfff, 0);
    {sf, bw, cr} = {4'd5, 2'd3, 3'd1};
    per = 32 * bwc[3];
    wb(1'b1, REG_MOD, modw(1'b0));
    wb(1'b1, REG_CTRL, 32'h31);
    repeat (2)
    begin
      s = 12'($urandom);
      tx_q.push_back(s & 12'h01f);
      wb(1'b1, REG_TXDATA, {20'h0, s});
    end
    while (tx_q.size() > 0)
      @(posedge clk);
    for (int k = 0; k < 4; k++)
    begin
      s = 12'($urandom % 32);
      if (k == 1 || k == 2)
        rxs.push_back(s);
      rx_sym <= s;
      rx_err <= (k == 0) ? 16'hfc18 : 16'h0190;
      rx_go  <= 1'b1;
      @(posedge clk);
      rx_go <= 1'b0;
      repeat (20) @(posedge clk);
    end
    rd(REG_STATUS, 32'h11, 32'h11, 0);
    rd(REG_RXDATA, {16'h0, 4'd5, rxs[0]}, 32'hffff, 0);
    rd(REG_RXDATA, {16'h0, 4'd5, rxs[1]}, 32'hffff, 0);
    rd(REG_STATUS, 32'h1, 32'h11, 0);
    chk({31'h0, afc !== 16'h0 && ^afc !== 1'bx}, 32'h1, 32'h1, 0);
    wb(1'b1, REG_STATUS, 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      wb(1'b1, REG_CTRL, (k == 2) ? 32'h41 : (k == 1) ? 32'hc2 : 32'h42);
      d = n_done;
      g = 40 + $urandom % 60;
      rng_gap <= 8'(g);
      rng_go  <= 1'b1;
      @(posedge clk);
      rng_go <= 1'b0;
      repeat (150) @(posedge clk);
      chk(32'(n_done - d), (k == 2) ? 32'h0 : 32'h1, 32'hffffffff, 0);
      if (k < 2)
        rd(REG_RANGE, (k == 1) ? g : g / 2, 32'hffffffff, 2);
    end
    wrap_up();
  end
endmodule : csm_modem_test

// *** bench/csm_peer.sv ***
// Purpose: Peer radio model: symbol sink, symbol source and a distant ranging pair.
// Assumes: Same clock as the modem core; every request is commanded by the bench.
// Notes:   Idle symbol lines toggle each cycle so stale data is never mistaken for valid.
`timescale 1ns/1ps
module csm_peer (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  output logic             tx_ready_o,
  input  wire logic        rx_go_i,
  input  wire logic [11:0] rx_sym_i,
  input  wire logic [15:0] rx_err_i,
  output logic             rx_valid_o,
  output logic [11:0]      rx_sym_o,
  output logic [15:0]      rx_err_o,
  input  wire logic        rng_go_i,
  input  wire logic [7:0]  rng_gap_i,
  output logic             rng_req_o,
  output logic             rng_rsp_o
);
  logic [7:0] cnt_r;

  // The sink stalls about one cycle in four.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tx_ready_o <= 1'b0;
    else
      tx_ready_o <= ($urandom % 4) != 0;
  end

  // One symbol per command, at the offset the bench picked.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_valid_o <= 1'b0;
      rx_sym_o   <= 12'h000;
      rx_err_o   <= 16'h0000;
    end
    else if (rx_go_i)
    begin
      rx_valid_o <= 1'b1;
      rx_sym_o   <= rx_sym_i;
      rx_err_o   <= rx_err_i;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      rx_sym_o   <= ~rx_sym_o;
      rx_err_o   <= ~rx_err_o;
    end
  end

  // Request rises at once, reply rises the given number of cycles later and stands two cycles.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r     <= 8'h00;
      rng_req_o <= 1'b0;
      rng_rsp_o <= 1'b0;
    end
    else if (rng_go_i)
    begin
      rng_req_o <= 1'b1;
      cnt_r     <= rng_gap_i;
    end
    else if (cnt_r != 8'h00)
    begin
      cnt_r     <= cnt_r - 8'h01;
      rng_rsp_o <= cnt_r == 8'h01;
    end
    else if (rng_rsp_o && rng_req_o)
      rng_req_o <= 1'b0;
    else if (rng_rsp_o)
      rng_rsp_o <= 1'b0;
  end
endmodule : csm_peer

// *** rtl/csm_buf2.sv ***
// Purpose: Two-entry valid/ready buffer on the symbol path.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Accepts no word while full, even in a cycle where one leaves.
`timescale 1ns/1ps
module csm_buf2 #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign in_ready_o  = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_r[wp_r] <= in_data_i;
  end

  a_buf_no_over: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_r <= 2'h2) else $error("buffer count out of range");
  a_buf_full_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt_r == 2'h2) |-> !in_ready_o) else $error("ready high while full");

endmodule : csm_buf2

// *** rtl/csm_modem.sv ***
// Purpose: Chirp spread modem parameter core with Wishbone registers and symbol path.
// Assumes: 40 MHz SYS_CLK_I, asynchronous active-low RST_N_I, classic Wishbone slave.
// Notes:   Symbols carry sf bits each; one symbol leaves per symbol period, received ones enter as they arrive.
// Function
// R1: Each symbol spans 2^sf chips, sf limited to 5..12.
// R2: Bandwidth code selects chip rate 203 to 1625 kHz.
// R3: Symbol period equals 2^sf chip periods of the bandwidth.
// R4: Raw bit rate is sf bits per symbol period.
// R5: Effective rate is raw rate times 4 over 4 plus code setting.
// R6: Code setting writable; optional header flag carries it to receiver.
// R7: Host selects packet format before modulation setting.
// R8: Both link ends share sf and bandwidth.
// R9: Frequency correction runs on its own, no host control.
// R10: One config path and one data buffer serve every modem type.
// R11: Receiver accepts static offset within a quarter of bandwidth.
// R12: Peer keeps drift under bw/(3*2^sf), sixteen-fold relaxed at sf 11, 12.
// R13: Ranging measures round trip time, needs the ranging format.
// R14: Advanced ranging reports request-to-reply time difference.
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module csm_modem
  import csm_pkg::*;
(
  input  wire logic              SYS_CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [csm_pkg::AW-1:0] WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [csm_pkg::DW-1:0] WB_DAT_I,
  output logic [csm_pkg::DW-1:0] WB_DAT_O,
  output logic                   WB_ACK_O,
  output logic                   TX_SYM_VALID_O,
  output logic [11:0]            TX_SYM_O,
  input  wire logic              TX_SYM_READY_I,
  input  wire logic              RX_SYM_VALID_I,
  input  wire logic [11:0]       RX_SYM_I,
  input  wire logic [15:0]       RX_FREQ_ERR_I,
  input  wire logic              RNG_REQ_I,
  input  wire logic              RNG_RSP_I,
  output logic [15:0]            AFC_TRIM_O,
  output logic                   RNG_DONE_O
);
  import csm_pkg::*;

  csm_fmt_t     fmt_r;
  csm_mod_t     mod_r;
  logic         mod_seen_r;
  logic         seq_err_r;
  logic         tx_en_r;
  logic         rx_en_r;
  logic         rng_en_r;
  logic         adv_r;
  logic         wb_hit;
  logic         wr;
  logic [7:0]   chip_cyc;
  logic [15:0]  bw_khz;
  logic         chip_stb;
  logic         sym_stb;
  logic         tb_in_ready;
  logic [15:0]  tb_out;
  logic         tb_out_valid;
  logic         rb_in_valid;
  logic         rb_in_ready;
  logic [15:0]  rb_out;
  logic         rb_out_valid;
  logic         rb_pop;
  logic         rx_ovf_r;
  logic         offset_ok;
  logic [15:0]  offset_lim;
  logic [15:0]  err_abs;
  logic [31:0]  raw_bps;
  logic [31:0]  eff_bps;
  logic [31:0]  drift_hz;
  logic [31:0]  rng_cnt_r;
  logic [31:0]  rng_res_r;
  logic         rng_run_r;
  logic [2:0]   req_s_r;
  logic [2:0]   rsp_s_r;
  logic [15:0]  afc_r;
  logic         tx_push;
  logic [11:0]  sym_mask;
  logic [11:0]  sym_gap_r;
  logic         sym_gap_ok_r;
  logic         sym_watch;
  logic         req_lvl_r;
  logic         rsp_lvl_r;

  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr     = wb_hit && WB_WE_I;

  // Packet format and run controls.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      fmt_r    <= FMT_NONE;
      tx_en_r  <= 1'b0;
      rx_en_r  <= 1'b0;
      rng_en_r <= 1'b0;
      adv_r    <= 1'b0;
    end
    else if (wr && WB_ADR_I == REG_CTRL && WB_SEL_I[0])
    begin
      fmt_r    <= csm_fmt_t'(WB_DAT_I[CTL_FMT_LSB +: 2]);
      tx_en_r  <= WB_DAT_I[CTL_TX_BIT];
      rx_en_r  <= WB_DAT_I[CTL_RX_BIT];
      rng_en_r <= WB_DAT_I[CTL_RNG_BIT] && (WB_DAT_I[CTL_FMT_LSB +: 2] == 2'(FMT_RANGING)); // R13
      adv_r    <= WB_DAT_I[CTL_ADV_BIT];
    end
  end

  // Modulation settings; a write before any format selection is flagged and dropped.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      mod_r      <= '{sf: SF_RST, bw: BW_RST, cr: CR_RST, hdr_cr: 1'b0};
      mod_seen_r <= 1'b0;
      seq_err_r  <= 1'b0;
    end
    else if (wr && WB_ADR_I == REG_MOD && WB_SEL_I[1:0] == 2'h3)
    begin
      if (fmt_r == FMT_NONE)
        seq_err_r <= 1'b1; // R7
      else
      begin
        mod_seen_r <= 1'b1;
        if (WB_DAT_I[MOD_SF_LSB +: 4] >= 4'(SF_MIN) && WB_DAT_I[MOD_SF_LSB +: 4] <= 4'(SF_MAX))
          mod_r.sf <= WB_DAT_I[MOD_SF_LSB +: 4]; // R1 R8
        mod_r.bw     <= WB_DAT_I[MOD_BW_LSB +: 2]; // R2 R8
        if (WB_DAT_I[MOD_CR_LSB +: 3] != 3'h0)
          mod_r.cr <= WB_DAT_I[MOD_CR_LSB +: 3]; // R6
        mod_r.hdr_cr <= WB_DAT_I[MOD_HD_BIT]; // R6
      end
    end
    else if (wr && WB_ADR_I == REG_STATUS && WB_DAT_I[1])
      seq_err_r <= 1'b0;
  end

  always_comb
  begin
    unique case (mod_r.bw)
      2'h0:    begin chip_cyc = BW_CYC0; bw_khz = BW_KHZ0; end
      2'h1:    begin chip_cyc = BW_CYC1; bw_khz = BW_KHZ1; end
      2'h2:    begin chip_cyc = BW_CYC2; bw_khz = BW_KHZ2; end
      default: begin chip_cyc = BW_CYC3; bw_khz = BW_KHZ3; end
    endcase
  end

  // Rate figures: raw bps, and for software effective bps and peer drift limit in Hz.
  assign raw_bps  = (32'(bw_khz) * 32'd1000 * 32'(mod_r.sf)) >> mod_r.sf; // R3 R4
  assign eff_bps  = (raw_bps * 32'(CR_BASE)) / (32'(CR_BASE) + 32'(mod_r.cr)); // R5
  assign drift_hz = ((32'(bw_khz) * 32'd1000) / (32'(DRIFT_DIV) << mod_r.sf))
                    << ((mod_r.sf >= 4'(SF_RELAX)) ? RELAX_SH : 0); // R12

  csm_symtimer u_tmr (
    .clk_i      (SYS_CLK_I),
    .rst_n_i    (RST_N_I),
    .en_i       (mod_seen_r && (tx_en_r || rx_en_r)),
    .chip_cyc_i (chip_cyc),
    .sf_i       (mod_r.sf),
    .chip_o     (chip_stb),
    .sym_o      (sym_stb)
  ); // R1 R3

  // Counts cycles since the last symbol strobe while sf 5 at the widest bandwidth is kept.
  assign sym_watch = (mod_r.sf == 4'h5) && (mod_r.bw == 2'h3) && tx_en_r;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sym_gap_r    <= 12'h000;
      sym_gap_ok_r <= 1'b0;
    end
    else if (sym_stb)
    begin
      sym_gap_r    <= 12'h000;
      sym_gap_ok_r <= sym_watch;
    end
    else
    begin
      sym_gap_r <= sym_gap_r + 12'h001;
      if (!sym_watch)
        sym_gap_ok_r <= 1'b0;
    end
  end

  assign sym_mask = 12'((13'h1 << mod_r.sf) - 13'h1);
  assign tx_push  = wr && WB_ADR_I == REG_TXDATA && tb_in_ready;

  // Shared data buffer pair for every modem type.
  csm_buf2 #(.W(16)) u_txbuf (
    .clk_i       (SYS_CLK_I),
    .rst_n_i     (RST_N_I),
    .in_data_i   ({mod_r.sf, WB_DAT_I[11:0] & sym_mask}),
    .in_valid_i  (tx_push),
    .in_ready_o  (tb_in_ready),
    .out_data_o  (tb_out),
    .out_valid_o (tb_out_valid),
    .out_ready_i (tx_en_r && sym_stb && (!TX_SYM_VALID_O || TX_SYM_READY_I))
  ); // R10

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      TX_SYM_VALID_O <= 1'b0;
      TX_SYM_O       <= 12'h000;
    end
    else if (tx_en_r && sym_stb && tb_out_valid && (!TX_SYM_VALID_O || TX_SYM_READY_I))
    begin
      TX_SYM_VALID_O <= 1'b1; // R4
      TX_SYM_O       <= tb_out[11:0];
    end
    else if (TX_SYM_READY_I)
      TX_SYM_VALID_O <= 1'b0;
  end

  // Static offset check: symbols are taken while the error, or the error less the AFC trim, is within bw/4.
  assign err_abs    = RX_FREQ_ERR_I[15] ? 16'(-RX_FREQ_ERR_I) : RX_FREQ_ERR_I;
  assign offset_lim = bw_khz >> OFFSET_SH;
  assign offset_ok  = (16'(err_abs - afc_r) <= offset_lim) || (err_abs <= offset_lim); // R11
  assign rb_in_valid = rx_en_r && RX_SYM_VALID_I && offset_ok;
  assign rb_pop      = wb_hit && !WB_WE_I && WB_ADR_I == REG_RXDATA;

  csm_buf2 #(.W(16)) u_rxbuf (
    .clk_i       (SYS_CLK_I),
    .rst_n_i     (RST_N_I),
    .in_data_i   ({mod_r.sf, RX_SYM_I & sym_mask}),
    .in_valid_i  (rb_in_valid),
    .in_ready_o  (rb_in_ready),
    .out_data_o  (rb_out),
    .out_valid_o (rb_out_valid),
    .out_ready_i (rb_pop)
  ); // R10

  // Overflow is sticky; a new loss in the clearing cycle keeps it set.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rx_ovf_r <= 1'b0;
    else if (rb_in_valid && !rb_in_ready)
      rx_ovf_r <= 1'b1;
    else if (wr && WB_ADR_I == REG_STATUS && WB_DAT_I[0])
      rx_ovf_r <= 1'b0;
  end

  // Autonomous frequency correction: trim tracks the measured error by 1/8 steps.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      afc_r <= 16'h0000;
    else if (rx_en_r && RX_SYM_VALID_I)
      afc_r <= afc_r + 16'($signed(RX_FREQ_ERR_I - afc_r) >>> 3); // R9
  end
  assign AFC_TRIM_O = afc_r;

  // Ranging pin inputs pass three flops; a new level counts once stages two and three agree.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      req_s_r   <= 3'h0;
      rsp_s_r   <= 3'h0;
      req_lvl_r <= 1'b0;
      rsp_lvl_r <= 1'b0;
    end
    else
    begin
      req_s_r <= {req_s_r[1:0], RNG_REQ_I};
      rsp_s_r <= {rsp_s_r[1:0], RNG_RSP_I};
      if (req_s_r[1] == req_s_r[2])
        req_lvl_r <= req_s_r[2];
      if (rsp_s_r[1] == rsp_s_r[2])
        rsp_lvl_r <= rsp_s_r[2];
    end
  end

  // Ranging timer: counts from request to reply, both own exchange and overheard one.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rng_run_r  <= 1'b0;
      rng_cnt_r  <= 32'h0000_0000;
      rng_res_r  <= 32'h0000_0000;
      RNG_DONE_O <= 1'b0;
    end
    else
    begin
      RNG_DONE_O <= 1'b0;
      if (rng_en_r && req_s_r[1] && req_s_r[2] && !req_lvl_r)
      begin
        rng_run_r <= 1'b1; // R13 R14
        rng_cnt_r <= 32'h0000_0000;
      end
      else if (rng_run_r && rsp_s_r[1] && rsp_s_r[2] && !rsp_lvl_r)
      begin
        rng_run_r  <= 1'b0;
        rng_res_r  <= adv_r ? rng_cnt_r : (rng_cnt_r >> 1); // R13 R14
        RNG_DONE_O <= 1'b1;
      end
      else if (rng_run_r)
        rng_cnt_r <= rng_cnt_r + 32'h0000_0001;
    end
  end

  // Wishbone answer: ack one cycle after the strobe, dropped the cycle after.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= wb_hit;
      if (wb_hit && !WB_WE_I)
      begin
        unique case (WB_ADR_I)
          REG_CTRL:   WB_DAT_O <= {24'h0, adv_r, rng_en_r, rx_en_r, tx_en_r, 2'h0, fmt_r};
          REG_MOD:    WB_DAT_O <= {20'h0, mod_r.hdr_cr, mod_r.cr, 2'h0, mod_r.bw, mod_r.sf};
          REG_STATUS: WB_DAT_O <= {26'h0, rng_run_r, rb_out_valid, tb_in_ready,
                                   mod_seen_r, seq_err_r, rx_ovf_r};
          REG_RXDATA: WB_DAT_O <= {16'h0, rb_out};
          REG_RATE:   WB_DAT_O <= eff_bps;
          REG_DRIFT:  WB_DAT_O <= drift_hz;
          REG_RANGE:  WB_DAT_O <= rng_res_r;
          REG_AFC:    WB_DAT_O <= {16'h0, afc_r};
          default:    WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_wb_ack_one: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");
  a_sf_range_ok: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R1
    mod_r.sf >= 4'(SF_MIN) && mod_r.sf <= 4'(SF_MAX)) else $error("sf out of range");
  a_bw_chip_map: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R2
    (mod_r.bw == 2'h3) |-> chip_cyc == BW_CYC3) else $error("bandwidth map wrong");
  a_sym_period: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R3
    (sym_stb && sym_gap_ok_r && sym_watch) |-> sym_gap_r == 12'd799)
    else $error("symbol period wrong");
  a_raw_rate: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R4
    (mod_r.sf == 4'h5 && mod_r.bw == 2'h0) |-> raw_bps == 32'd31718)
    else $error("raw rate wrong");
  a_eff_rate: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R5
    (mod_r.cr == 3'h4) |-> eff_bps == (raw_bps >> 1)) else $error("coded rate wrong");
  a_mod_order: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R7
    (wr && WB_ADR_I == REG_MOD && fmt_r == FMT_NONE) |=> seq_err_r && $stable(mod_r))
    else $error("setting taken before format");
  a_rx_offset: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R11
    (rx_en_r && RX_SYM_VALID_I && err_abs <= offset_lim) |-> rb_in_valid)
    else $error("in-range offset refused");
  a_rng_done: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R14
    RNG_DONE_O |-> $past(rng_run_r) && !rng_run_r) else $error("range done stray");
  a_rng_format: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I) // R13
    rng_en_r |-> fmt_r == FMT_RANGING) else $error("ranging without format");

endmodule : csm_modem

// *** rtl/csm_pkg.sv ***
// Purpose: Shared constants and types of the chirp spread modem parameter block.
// Assumes: 40 MHz system clock, classic Wishbone register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package csm_pkg;

  localparam int unsigned CLK_HZ     = 40000000;
  localparam int unsigned AW         = 8;
  localparam int unsigned DW         = 32;

  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_MOD     = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_TXDATA  = 8'h0c;
  localparam logic [7:0] REG_RXDATA  = 8'h10;
  localparam logic [7:0] REG_RATE    = 8'h14;
  localparam logic [7:0] REG_DRIFT   = 8'h18;
  localparam logic [7:0] REG_RANGE   = 8'h1c;
  localparam logic [7:0] REG_AFC     = 8'h20;

  localparam int unsigned SF_MIN     = 5;
  localparam int unsigned SF_MAX     = 12;
  localparam int unsigned SF_RELAX   = 11;
  localparam int unsigned RELAX_SH   = 4;
  localparam int unsigned CR_BASE    = 4;
  localparam int unsigned DRIFT_DIV  = 3;
  localparam int unsigned OFFSET_SH  = 2;

  // Modulation bandwidth codes and their chip rate in kHz.
  localparam logic [15:0] BW_KHZ0    = 16'h00cb;
  localparam logic [15:0] BW_KHZ1    = 16'h0196;
  localparam logic [15:0] BW_KHZ2    = 16'h032c;
  localparam logic [15:0] BW_KHZ3    = 16'h0659;
  // Chip period in system cycles for each bandwidth code (40 MHz / chip rate, rounded).
  localparam logic [7:0]  BW_CYC0    = 8'hc5;
  localparam logic [7:0]  BW_CYC1    = 8'h62;
  localparam logic [7:0]  BW_CYC2    = 8'h31;
  localparam logic [7:0]  BW_CYC3    = 8'h19;

  localparam logic [3:0]  SF_RST     = 4'h7;
  localparam logic [1:0]  BW_RST     = 2'h0;
  localparam logic [2:0]  CR_RST     = 3'h1;

  // Field positions within REG_MOD.
  localparam int unsigned MOD_SF_LSB = 0;
  localparam int unsigned MOD_BW_LSB = 4;
  localparam int unsigned MOD_CR_LSB = 8;
  localparam int unsigned MOD_HD_BIT = 11;
  // Field positions within REG_CTRL.
  localparam int unsigned CTL_FMT_LSB = 0;
  localparam int unsigned CTL_TX_BIT  = 4;
  localparam int unsigned CTL_RX_BIT  = 5;
  localparam int unsigned CTL_RNG_BIT = 6;
  localparam int unsigned CTL_ADV_BIT = 7;

  typedef enum logic [1:0] {FMT_NONE, FMT_CHIRP, FMT_RANGING, FMT_OTHER} csm_fmt_t;

  typedef struct packed {
    logic [3:0] sf;
    logic [1:0] bw;
    logic [2:0] cr;
    logic       hdr_cr;
  } csm_mod_t;

  typedef struct packed {
    logic [11:0] sym;
    logic [3:0]  bits;
  } csm_sym_t;

endpackage : csm_pkg

// *** rtl/csm_symtimer.sv ***
// Purpose: Symbol period timer: one chip strobe per bandwidth period, 2^sf chips per symbol.
// Assumes: Single clock; chip period given in system cycles.
// Notes:   Restarts whenever enable drops; a new setting written while enabled is taken mid-count.
`timescale 1ns/1ps
module csm_symtimer (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  input  wire logic [7:0] chip_cyc_i,
  input  wire logic [3:0] sf_i,
  output logic            chip_o,
  output logic            sym_o
);
  logic [7:0]  div_r;
  logic [11:0] chip_r;
  logic [11:0] last_chip;

  assign last_chip = 12'((13'h1 << sf_i) - 13'h1);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_r  <= 8'h00;
      chip_r <= 12'h000;
      chip_o <= 1'b0;
      sym_o  <= 1'b0;
    end
    else if (!en_i)
    begin
      div_r  <= 8'h00;
      chip_r <= 12'h000;
      chip_o <= 1'b0;
      sym_o  <= 1'b0;
    end
    else
    begin
      chip_o <= 1'b0;
      sym_o  <= 1'b0;
      if (div_r == chip_cyc_i - 8'h01)
      begin
        div_r  <= 8'h00;
        chip_o <= 1'b1;
        if (chip_r == last_chip)
        begin
          chip_r <= 12'h000;
          sym_o  <= 1'b1;
        end
        else
          chip_r <= chip_r + 12'h001;
      end
      else
        div_r <= div_r + 8'h01;
    end
  end

  a_sym_chip_pair: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sym_o |-> chip_o) else $error("symbol strobe without chip strobe");

endmodule : csm_symtimer
